// *** rtl/irq_power_pkg.sv ***
// Constants for the interrupt and low-power control block.
// Contract
// - Fixed vectors, reset highest, timer lowest.
// - Programmable and alternate requests: edge or level.
// - Level-only inputs level, edge-only input edge.
// - Alternate requests share serial port b vectors.
// - Requests ANDed with mask; power-down unmaskable.
// - Block interrupts one cycle after mask write.
// - Control register selects nesting and sense.
// - Write-only force/clear register sets or clears.
// - Status stack twelve deep, push and pop.
// - Global enable gates all interrupts.
// - Global servicing enabled after reset.
// - Idle stalls until unmasked interrupt arrives.
// - Slow idle divides clock by 16-240, in steps of 16.
// - Slow idle wakes within n cycles.
// - Power-down from pin or force bit.
// - Resume after 100 or 4096 input clocks.
// - Power-down request raises edge power-down interrupt.
// - Context setting selects continue or clear.
// - Reset terminates power-down.
// - Acknowledge output once powered down.
// - Cycle clock output, disable bit stops it.
// - Master reset empties stacks, masks all.
package irq_power_pkg;
  // ****************************************************************
  // Register map (word addresses are byte offsets, one word each).
  // ****************************************************************
  localparam logic [7:0] ADDR_MASK = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_FORCE_CLEAR = 8'h08;
  localparam logic [7:0] ADDR_PENDING = 8'h0c;
  localparam logic [7:0] ADDR_SEQ_CMD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_MODE = 8'h18;
  // ****************************************************************
  // Sources, bit index = priority slot (0 highest after reset).
  // ****************************************************************
  localparam int NSRC = 11;
  localparam int SRC_PWD = 0;
  localparam int SRC_PROG = 1;
  localparam int SRC_LVLB = 2;
  localparam int SRC_LVLA = 3;
  localparam int SRC_SPA_TX = 4;
  localparam int SRC_SPA_RX = 5;
  localparam int SRC_EDGE = 6;
  localparam int SRC_DMA = 7;
  localparam int SRC_SPB_TX = 8;
  localparam int SRC_SPB_RX = 9;
  localparam int SRC_TIMER = 10;
  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_PWD = 14'h002c;
  localparam logic [13:0] VEC_BASE = 14'h0004;
  localparam logic [13:0] VEC_STEP = 14'h0004;
  // ****************************************************************
  // Control register fields.
  // ****************************************************************
  localparam int CTRL_SENSE_ALTB = 0;
  localparam int CTRL_SENSE_ALTA = 1;
  localparam int CTRL_SENSE_PROG = 2;
  localparam int CTRL_NEST = 4;
  localparam int CTRL_SPB_ALT = 5;
  localparam int CTRL_CONTEXT = 6;
  localparam int CTRL_CLKOFF = 7;
  localparam int CTRL_CRYSTAL_PIN_STOP = 8;
  localparam int CTRL_W = 9;
  // Force/clear: bits 10:0 force, bits 26:16 clear, bit 31 power-down.
  localparam int FC_CLEAR_LSB = 16;
  localparam int FC_PWD_FORCE = 31;
  // Sequencer command codes.
  localparam logic [3:0] CMD_INT_ON = 4'h1;
  localparam logic [3:0] CMD_INT_OFF = 4'h2;
  localparam logic [3:0] CMD_IDLE = 4'h3;
  localparam logic [3:0] CMD_RTI = 4'h4;
  localparam logic [3:0] CMD_PWD_ENTER = 4'h5;
  localparam int STACK_DEPTH = 12;
  // ****************************************************************
  // Timing: input clock runs at half the 250 MHz cycle rate.
  // ****************************************************************
  localparam int INPUT_CLOCK_PER_CYCLE = 2;
  localparam int WAKE_RUN_INPUT_CLOCK = 100;
  localparam int WAKE_CRYSTAL_PIN_INPUT_CLOCK = 4096;
  localparam int WAKE_RUN_CYC = WAKE_RUN_INPUT_CLOCK * INPUT_CLOCK_PER_CYCLE;
  localparam int WAKE_CRYSTAL_PIN_CYC = WAKE_CRYSTAL_PIN_INPUT_CLOCK * INPUT_CLOCK_PER_CYCLE;
  typedef enum logic [1:0] {
    PS_RUN = 2'b00,
    PS_DOWN = 2'b01,
    PS_WAKE = 2'b11
  } pwr_state_t;
endpackage

// *** rtl/irq_power_ctrl.sv ***
// Interrupt priority, mask, stack and low-power sequencing block.
module irq_power_ctrl #(
  parameter int CRYSTAL_PIN_WAKE_CYC = irq_power_pkg::WAKE_CRYSTAL_PIN_CYC
) (
  input wire logic clk_i, // Cycle clock, 250 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic ext_request_programmable_n_i, // Pin, active low.
  input wire logic level_request_a_n_i, // Pin, active low.
  input wire logic level_request_b_n_i, // Pin, active low.
  input wire logic edge_request_n_i, // Pin, falling edge.
  input wire logic alt_request_a_n_i, // Pin, active low.
  input wire logic alt_request_b_n_i, // Pin, active low.
  input wire logic powerdown_in_n_i, // Pin, falling edge.
  input wire logic [4:0] periph_req_i, // Tx a, rx a, dma, tx b, rx b.
  output logic irq_valid_o, // Vector request to sequencer.
  output logic [13:0] irq_vector_o, // Vector address.
  input wire logic irq_take_i, // Sequencer accepts vector.
  output logic powerdown_ack_o, // Powered down.
  output logic context_clear_o, // Pulse: restart with clear context.
  output logic resume_o, // Pulse: execution resumes.
  output logic stall_o, // Sequencer held in idle.
  output logic slow_clk_en_o, // Divided clock enable.
  output logic cycle_clock_out_o // Cycle clock output.
);
  localparam int NS = irq_power_pkg::NSRC;
  localparam int DW = $clog2(irq_power_pkg::WAKE_CRYSTAL_PIN_CYC + 1);
  initial begin
    if (CRYSTAL_PIN_WAKE_CYC < 1 || CRYSTAL_PIN_WAKE_CYC >= (1 << DW))
      $error("CRYSTAL_PIN_WAKE_CYC out of range");
  end

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Lowest set index is the highest priority.
  function automatic logic [3:0] first_set(input logic [NS-1:0] v);
    logic [3:0] r;
    r = 4'hf;
    for (int k = NS - 1; k >= 0; k--) begin
      if (v[k]) r = 4'(k);
    end
    return r;
  endfunction

  function automatic logic [13:0] vec_of(input logic [3:0] s);
    if (s == 4'(irq_power_pkg::SRC_PWD)) return irq_power_pkg::VEC_PWD;
    return irq_power_pkg::VEC_BASE + 14'(s - 4'h1) * irq_power_pkg::VEC_STEP;
  endfunction

  // ****************************************************************
  // Pin synchronisers: three flops, change taken when 2nd and 3rd agree.
  // ****************************************************************
  logic [6:0] pin_raw, s1_reg, s2_reg, s3_reg, pin_reg;
  assign pin_raw = ~{powerdown_in_n_i, alt_request_b_n_i, alt_request_a_n_i,
                     edge_request_n_i, level_request_b_n_i,
                     level_request_a_n_i, ext_request_programmable_n_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= 7'h00;
      s2_reg <= 7'h00;
      s3_reg <= 7'h00;
      pin_reg <= 7'h00;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int k = 0; k < 7; k++) begin
        if (s2_reg[k] == s3_reg[k]) pin_reg[k] <= s3_reg[k];
      end
    end
  end
  logic [6:0] pin_prev_reg;
  logic [6:0] pin_rise;
  always_ff @(posedge clk_i) begin
    if (rst_i) pin_prev_reg <= 7'h00;
    else pin_prev_reg <= pin_reg;
  end
  assign pin_rise = pin_reg & ~pin_prev_reg;

  // ****************************************************************
  // Software registers.
  // ****************************************************************
  logic [NS-1:0] interrupt_mask_reg;
  logic [irq_power_pkg::CTRL_W-1:0] interrupt_control_reg;
  logic wr, rd_ok, mask_wr, fc_wr, cmd_wr, ack_reg;
  logic [3:0] cmd;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
  assign mask_wr = wr && wb_adr_i == irq_power_pkg::ADDR_MASK;
  assign fc_wr = wr && wb_adr_i == irq_power_pkg::ADDR_FORCE_CLEAR;
  assign cmd_wr = wr && wb_adr_i == irq_power_pkg::ADDR_SEQ_CMD
                  && wb_sel_i[0];
  assign cmd = cmd_wr ? wb_dat_i[3:0] : 4'h0;

  // reset masks all; mask write path.
  always_ff @(posedge clk_i) begin
    if (rst_i) interrupt_mask_reg <= '0;
    else if (mask_wr && wb_sel_i[0] && wb_sel_i[1])
      interrupt_mask_reg <= wb_dat_i[NS-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) interrupt_control_reg <= '0;
    else if (wr && wb_adr_i == irq_power_pkg::ADDR_CTRL && wb_sel_i[0]
             && wb_sel_i[1])
      interrupt_control_reg <= wb_dat_i[irq_power_pkg::CTRL_W-1:0];
  end
  logic nest_on, spb_alt, ctx_clear, clk_off, crystal_pin_stop;
  assign nest_on = interrupt_control_reg[irq_power_pkg::CTRL_NEST];
  assign spb_alt = interrupt_control_reg[irq_power_pkg::CTRL_SPB_ALT];
  assign ctx_clear = interrupt_control_reg[irq_power_pkg::CTRL_CONTEXT];
  assign clk_off = interrupt_control_reg[irq_power_pkg::CTRL_CLKOFF];
  assign crystal_pin_stop = interrupt_control_reg[irq_power_pkg::CTRL_CRYSTAL_PIN_STOP];

  // one-cycle block after any mask write.
  logic mask_block_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) mask_block_reg <= 1'b0;
    else mask_block_reg <= mask_wr;
  end

  logic global_int_on_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) global_int_on_reg <= 1'b1;
    else if (cmd == irq_power_pkg::CMD_INT_ON) global_int_on_reg <= 1'b1;
    else if (cmd == irq_power_pkg::CMD_INT_OFF) global_int_on_reg <= 1'b0;
  end

  // ****************************************************************
  // Request sensing and pending latches.
  // ****************************************************************
  logic [NS-1:0] edge_sense, raw_level, raw_edge, force_bits, clr_bits;
  logic [NS-1:0] pending_reg, active;
  logic pwd_force;
  // software-selected sense; alternate pins on port b vectors.
  // fixed sense for level-only and edge-only pins.
  always_comb begin
    edge_sense = '0;
    edge_sense[irq_power_pkg::SRC_PWD] = 1'b1;
    edge_sense[irq_power_pkg::SRC_EDGE] = 1'b1;
    edge_sense[irq_power_pkg::SRC_PROG] =
      interrupt_control_reg[irq_power_pkg::CTRL_SENSE_PROG];
    edge_sense[irq_power_pkg::SRC_SPB_TX] = spb_alt &
      interrupt_control_reg[irq_power_pkg::CTRL_SENSE_ALTB];
    edge_sense[irq_power_pkg::SRC_SPB_RX] = spb_alt &
      interrupt_control_reg[irq_power_pkg::CTRL_SENSE_ALTA];
    raw_level = '0;
    raw_level[irq_power_pkg::SRC_PROG] = pin_reg[0];
    raw_level[irq_power_pkg::SRC_LVLA] = pin_reg[1];
    raw_level[irq_power_pkg::SRC_LVLB] = pin_reg[2];
    raw_level[irq_power_pkg::SRC_SPA_TX] = periph_req_i[0];
    raw_level[irq_power_pkg::SRC_SPA_RX] = periph_req_i[1];
    raw_level[irq_power_pkg::SRC_DMA] = periph_req_i[2];
    raw_level[irq_power_pkg::SRC_SPB_TX] =
      spb_alt ? pin_reg[5] : periph_req_i[3];
    raw_level[irq_power_pkg::SRC_SPB_RX] =
      spb_alt ? pin_reg[4] : periph_req_i[4];
    raw_edge = '0;
    raw_edge[irq_power_pkg::SRC_PWD] = pin_rise[6];
    raw_edge[irq_power_pkg::SRC_PROG] = pin_rise[0];
    raw_edge[irq_power_pkg::SRC_EDGE] = pin_rise[3];
    raw_edge[irq_power_pkg::SRC_SPB_TX] = pin_rise[5];
    raw_edge[irq_power_pkg::SRC_SPB_RX] = pin_rise[4];
  end

  assign force_bits = fc_wr ? wb_dat_i[NS-1:0] : '0;
  assign clr_bits = fc_wr ?
    wb_dat_i[irq_power_pkg::FC_CLEAR_LSB +: NS] : '0;
  assign pwd_force = fc_wr & wb_dat_i[irq_power_pkg::FC_PWD_FORCE];

  logic take;
  logic [3:0] sel_src;
  logic [NS-1:0] take_bits;
  assign take_bits = take ? (NS'(1) << sel_src) : '0;

  // edge latch held until serviced or cleared; set wins.
  // power-down request raises edge power-down interrupt.
  always_ff @(posedge clk_i) begin
    if (rst_i) pending_reg <= '0;
    else begin
      for (int k = 0; k < NS; k++) begin
        if ((edge_sense[k] && raw_edge[k]) || force_bits[k]
            || (k == irq_power_pkg::SRC_PWD && pwd_force))
          pending_reg[k] <= 1'b1;
        else if (clr_bits[k] || take_bits[k])
          pending_reg[k] <= 1'b0;
      end
    end
  end
  assign active = pending_reg | (raw_level & ~edge_sense);

  // ****************************************************************
  // Priority selection and status stack.
  // ****************************************************************
  logic [NS-1:0] eligible;
  logic [3:0] depth_reg;
  logic [3:0] stack_reg [irq_power_pkg::STACK_DEPTH];
  logic [3:0] cur_reg;
  logic in_handler;
  assign in_handler = depth_reg != 4'h0;
  // mask AND, power-down bypasses mask; global gate.
  always_comb begin
    eligible = active & interrupt_mask_reg;
    eligible[irq_power_pkg::SRC_PWD] = active[irq_power_pkg::SRC_PWD];
    if (!global_int_on_reg || mask_block_reg) eligible = '0;
  end
  logic full_stk;
  assign full_stk = depth_reg == 4'(irq_power_pkg::STACK_DEPTH);
  // fixed priority; nesting only preempts lower.
  assign sel_src = first_set(eligible);
  logic can_take;
  assign can_take = sel_src != 4'hf && !full_stk &&
    (!in_handler || (nest_on && sel_src < cur_reg));
  assign irq_valid_o = can_take;
  assign irq_vector_o = vec_of(sel_src);
  assign take = can_take & irq_take_i;

  // push on entry, pop on return; empty after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      depth_reg <= 4'h0;
      cur_reg <= 4'hf;
    end else if (take) begin
      stack_reg[depth_reg] <= cur_reg;
      depth_reg <= depth_reg + 4'h1;
      cur_reg <= sel_src;
    end else if (cmd == irq_power_pkg::CMD_RTI && in_handler) begin
      depth_reg <= depth_reg - 4'h1;
      cur_reg <= stack_reg[depth_reg - 4'h1];
    end
  end

  // ****************************************************************
  // Idle and slow idle.
  // ****************************************************************
  logic idle_reg;
  logic [7:0] div_reg, divcnt_reg;
  // stall until an unmasked interrupt; divisor select.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_reg <= 1'b0;
      div_reg <= 8'h00;
    end else if (cmd == irq_power_pkg::CMD_IDLE) begin
      idle_reg <= 1'b1;
      div_reg <= wb_dat_i[11:4] & 8'hf0;
    end else if (idle_reg && sel_src != 4'hf && divcnt_reg == 8'h00)
      idle_reg <= 1'b0;
  end
  // wake at next divided tick, within n cycles.
  always_ff @(posedge clk_i) begin
    if (rst_i || !idle_reg || div_reg == 8'h00) divcnt_reg <= 8'h00;
    else if (divcnt_reg == div_reg - 8'h01) divcnt_reg <= 8'h00;
    else divcnt_reg <= divcnt_reg + 8'h01;
  end
  assign slow_clk_en_o = ~idle_reg | divcnt_reg == 8'h00;

  // ****************************************************************
  // Power-down sequencing.
  // ****************************************************************
  irq_power_pkg::pwr_state_t pstate_reg;
  logic [DW-1:0] wake_reg;
  logic wake_now;
  assign wake_now = pin_reg[6] == 1'b0 && pin_prev_reg[6] == 1'b0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pstate_reg <= irq_power_pkg::PS_RUN;
      wake_reg <= '0;
    end else begin
      case (pstate_reg)
        irq_power_pkg::PS_RUN: begin
          if (cmd == irq_power_pkg::CMD_PWD_ENTER)
            pstate_reg <= irq_power_pkg::PS_DOWN;
        end
        irq_power_pkg::PS_DOWN: begin
          if (wake_now) begin
            pstate_reg <= irq_power_pkg::PS_WAKE;
            wake_reg <= crystal_pin_stop ? DW'(CRYSTAL_PIN_WAKE_CYC - 1) :
              DW'(irq_power_pkg::WAKE_RUN_CYC - 1);
          end
        end
        irq_power_pkg::PS_WAKE: begin
          if (wake_reg == '0) pstate_reg <= irq_power_pkg::PS_RUN;
          else wake_reg <= wake_reg - DW'(1);
        end
        default: pstate_reg <= irq_power_pkg::PS_RUN;
      endcase
    end
  end
  logic resume_p, ack_r;
  assign resume_p = pstate_reg == irq_power_pkg::PS_WAKE && wake_reg == '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      resume_o <= 1'b0;
      context_clear_o <= 1'b0;
    end else begin
      ack_r <= pstate_reg == irq_power_pkg::PS_DOWN;
      resume_o <= resume_p;
      context_clear_o <= resume_p & ctx_clear;
    end
  end
  assign powerdown_ack_o = ack_r;
  assign stall_o = idle_reg | (pstate_reg != irq_power_pkg::PS_RUN);

  // cycle clock output, gated by disable and slow idle.
  logic cko_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) cko_reg <= 1'b0;
    else if (clk_off || pstate_reg != irq_power_pkg::PS_RUN) cko_reg <= 1'b0;
    else if (slow_clk_en_o) cko_reg <= ~cko_reg;
  end
  assign cycle_clock_out_o = cko_reg;

  // ****************************************************************
  // Wishbone slave: ack one cycle after request, reads registered.
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
      case (wb_adr_i)
        irq_power_pkg::ADDR_MASK: wb_dat_o <= 32'(interrupt_mask_reg);
        irq_power_pkg::ADDR_CTRL: wb_dat_o <= 32'(interrupt_control_reg);
        irq_power_pkg::ADDR_PENDING: wb_dat_o <= 32'(active);
        irq_power_pkg::ADDR_STATUS:
          wb_dat_o <= {16'h0000, cur_reg, depth_reg, 3'h0,
                       global_int_on_reg, 2'(pstate_reg), idle_reg, ack_r};
        irq_power_pkg::ADDR_MODE: wb_dat_o <= {24'h000000, div_reg};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_ack_o = ack_reg;
  assign rd_ok = 1'b1;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  AST_MASK_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    mask_wr |=> !irq_valid_o) else $error("irq after mask write");
  AST_GLOBAL_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !global_int_on_reg |-> !irq_valid_o)
    else $error("irq while disabled");
  AST_PWD_VEC: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_valid_o && sel_src == 4'h0 |-> irq_vector_o == 14'h002c)
    else $error("bad power-down vector");
  AST_MASKED: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_valid_o && sel_src != 4'h0 |-> interrupt_mask_reg[sel_src])
    else $error("masked source taken");
  AST_STACK: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> depth_reg == $past(depth_reg) + 4'h1)
    else $error("stack push lost");
  AST_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
    pstate_reg == irq_power_pkg::PS_DOWN && wake_now && !crystal_pin_stop
    |-> ##201 resume_o) else $error("wake not 100 clocks");
  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    pstate_reg == irq_power_pkg::PS_DOWN |=> powerdown_ack_o)
    else $error("no power-down ack");
  AST_CLKOFF: assert property (@(posedge clk_i) disable iff (rst_i)
    clk_off |=> !cycle_clock_out_o) else $error("clock out on");
  AST_EDGE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    pending_reg[6] && !take_bits[6] && !clr_bits[6] |=> pending_reg[6])
    else $error("edge pending lost");
endmodule

// *** tb/irq_far_side.sv ***
// Far-side model: request pin drivers and a vector-taking sequencer.
module irq_far_side (
  input wire logic clk_i, // Cycle clock.
  input wire logic [6:0] req_i, // Requests from the bench, active high.
  input wire logic take_en_i, // Lets the sequencer accept vectors.
  input wire logic irq_valid_i, // Vector offered by the block.
  output logic [6:0] pin_n_o, // Request pins, active low.
  output logic irq_take_o // Accept pulse.
);
  timeunit 1ns;
  timeprecision 1ps;
  // power-down pin
  // Pins are plain push-pull drivers, so no released state exists.
  assign pin_n_o = ~req_i;
  // Takes one cycle after an offer, then leaves a gap so no take repeats.
  always_ff @(posedge clk_i) begin
    irq_take_o <= take_en_i && irq_valid_i && !irq_take_o;
  end
endmodule

// *** tb/irq_power_ctrl_bench.sv ***
// Self-checking bench for the interrupt and power control block.
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module irq_power_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_ack_o;
  logic [6:0] req = 7'h00;
  logic [6:0] pin_n;
  logic take_en = 1'b0;
  logic irq_valid_o, irq_take_i, powerdown_ack_o, context_clear_o;
  logic resume_o, stall_o, slow_clk_en_o, cycle_clock_out_o, v;
  logic [13:0] irq_vector_o;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int cnt = 0;
  // Short crystal wake count keeps the run brief.
  irq_power_ctrl #(.CRYSTAL_PIN_WAKE_CYC(20)) irq_power_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .ext_request_programmable_n_i(pin_n[0]),
    .level_request_a_n_i(pin_n[1]), .level_request_b_n_i(pin_n[2]),
    .edge_request_n_i(pin_n[3]), .alt_request_a_n_i(pin_n[4]),
    .alt_request_b_n_i(pin_n[5]), .powerdown_in_n_i(pin_n[6]),
    .periph_req_i(5'h00), .irq_valid_o(irq_valid_o),
    .irq_vector_o(irq_vector_o), .irq_take_i(irq_take_i),
    .powerdown_ack_o(powerdown_ack_o), .context_clear_o(context_clear_o),
    .resume_o(resume_o), .stall_o(stall_o), .slow_clk_en_o(slow_clk_en_o),
    .cycle_clock_out_o(cycle_clock_out_o));
  irq_far_side irq_far_side_inst (.clk_i(clk_i), .req_i(req),
    .take_en_i(take_en), .irq_valid_i(irq_valid_o), .pin_n_o(pin_n),
    .irq_take_o(irq_take_i));
  // ****************************************************************
  // Clock, hang ceiling and bus tasks.
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // A hung wait would otherwise stall the run forever.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Classic single cycle; held until ack, released one cycle after.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // Only the cycle ceiling ends a wait for a missing acknowledge.
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cmd(input logic [31:0] c);
    wb(irq_power_pkg::ADDR_SEQ_CMD, 1'b1, c);
  endtask
  // Waits for a taken vector and compares it.
  task automatic expect_vec(input logic [13:0] e);
    int n;
    n = 0;
    while (!(irq_valid_o === 1'b1 && irq_take_i === 1'b1) && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(irq_vector_o, e)
    @(posedge clk_i);
  endtask
  task automatic pd_test(input logic [31:0] ctl, input int lo, input int hi);
    int n;
    wb(irq_power_pkg::ADDR_CTRL, 1'b1, ctl);
    req[6] <= 1'b1;
    expect_vec(irq_power_pkg::VEC_PWD);
    cmd(32'h5);
    repeat (4) @(posedge clk_i);
    `CHK(powerdown_ack_o, 1'b1)
    req[6] <= 1'b0;
    n = 0;
    while (resume_o !== 1'b1 && n < 9000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    `CHK(context_clear_o, ctl[irq_power_pkg::CTRL_CONTEXT])
    cmd(32'h4);
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(irq_power_pkg::ADDR_MASK, 1'b0, 32'h0);
    `CHK(q[10:0], 11'h000)
    wb(irq_power_pkg::ADDR_STATUS, 1'b0, 32'h0);
    `CHK({q[11:8], q[4]}, 5'h01)
    wb(8'h80, 1'b1, 32'hffff);
    wb(8'h80, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    // Every source but power-down, forced at once, drains strictly by priority.
    wb(irq_power_pkg::ADDR_MASK, 1'b1, 32'h7fe);
    wb(irq_power_pkg::ADDR_FORCE_CLEAR, 1'b1, 32'h7fe);
    `CHK(irq_vector_o, 14'h0004)
    take_en <= 1'b1;
    for (int i = 1; i <= 10; i++) begin
      expect_vec(14'(4 * i));
      wb(irq_power_pkg::ADDR_STATUS, 1'b0, 32'h0);
      `CHK(q[11:8], 4'h1)
      cmd(32'h4);
    end
    // Masked edge stays latched until cleared.
    wb(irq_power_pkg::ADDR_MASK, 1'b1, 32'h0);
    req[3] <= 1'b1;
    repeat (3) @(posedge clk_i);
    req[3] <= 1'b0;
    repeat (8) @(posedge clk_i);
    `CHK(irq_valid_o, 1'b0)
    wb(irq_power_pkg::ADDR_PENDING, 1'b0, 32'h0);
    `CHK(q[6], 1'b1)
    wb(irq_power_pkg::ADDR_FORCE_CLEAR, 1'b1, 32'h1 << 22);
    wb(irq_power_pkg::ADDR_PENDING, 1'b0, 32'h0);
    `CHK(q[6], 1'b0)
    // Global off holds back an unmasked level request.
    cmd(32'h2);
    wb(irq_power_pkg::ADDR_MASK, 1'b1, 32'h7fe);
    req[1] <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK(irq_valid_o, 1'b0)
    cmd(32'h1);
    expect_vec(14'h000c);
    req[1] <= 1'b0;
    // Let the level clear the synchroniser before returning.
    repeat (6) @(posedge clk_i);
    cmd(32'h4);
    // Serial port b pins as an edge-sensed alternate request.
    wb(irq_power_pkg::ADDR_CTRL, 1'b1, 32'h22);
    req[4] <= 1'b1;
    expect_vec(14'h0024);
    req[4] <= 1'b0;
    cmd(32'h4);
    // Slow idle by 16, then woken by a level request.
    cmd(32'h103);
    cnt = 0;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_i);
      cnt += (slow_clk_en_o === 1'b1) ? 1 : 0;
    end
    `CHK(stall_o, 1'b1)
    `CHK(cnt, 2)
    req[2] <= 1'b1;
    expect_vec(14'h0008);
    // Wake waits for the next divided tick, at most 16 cycles.
    repeat (16) @(posedge clk_i);
    `CHK(stall_o, 1'b0)
    req[2] <= 1'b0;
    repeat (6) @(posedge clk_i);
    cmd(32'h4);
    // Cycle clock output runs, then stops when disabled.
    v = cycle_clock_out_o;
    @(posedge clk_i);
    `CHK(cycle_clock_out_o, ~v)
    wb(irq_power_pkg::ADDR_CTRL, 1'b1, 32'h80);
    v = cycle_clock_out_o;
    repeat (4) @(posedge clk_i);
    `CHK(cycle_clock_out_o, v)
    // Power-down with running clock, stopped crystal, then reset exit.
    pd_test(32'h0, 200, 212);
    pd_test(32'h140, 20, 32);
    req[6] <= 1'b1;
    expect_vec(irq_power_pkg::VEC_PWD);
    cmd(32'h5);
    req[6] <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(powerdown_ack_o, 1'b0)
    print_verdict();
  end
endmodule
